//--- dlc_channel.sv
// Controller end: one channel with list item fetch, write-back and chaining
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// How it works
// - Fetch destination word, never load it
// - Write back control A at fetch spot
// - Only length and finished bit updated
// - Fetch first item, chain immediately afterwards
// - Stop when sampled words match last setting
// - Software links items, sets source pointers
// - Software clears finished bits before enabling
// - Select bit one means hardware handshake
// - Enable command starts; completion clears status
// - Transfers run only with global bit 1
// - Suspend halts source reads into FIFO
// - Empty flag shows FIFO holds nothing
// - Partial word leftover counts as empty
// - Resume continues transfer to normal end
// - Disable is request; status clears later
// - Global clear requests disabling every channel
// - Data left in FIFO on disable dropped
// - Ack may be withheld during disable
// - Zero length with device flow disables
// - Peripheral drops requests on acknowledge
// - Software aligns pointers to word sizes
// - Enable channel before flow-owning peripheral
module dlc_channel
  import dlc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Link side
  dlc_link_if.ctrl LINK
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic global_on_reg;
  logic [31:0] channel_source_pointer, channel_dest_pointer, descriptor_pointer;
  logic [31:0] channel_control_a, channel_control_b, channel_config;
  logic [31:0] last_a_reg, last_b_reg, last_d_reg;
  logic en_reg, sus_reg, dis_req_reg, last_buf_reg;
  dlc_state_e state_reg;
  logic [2:0] word_reg;
  logic [31:0] item_base_reg;
  logic [7:0] fifo_bytes_reg;
  logic src_sel, dst_sel, len_zero, wr_done_cycle;
  logic [15:0] len;
  logic [7:0] sws, dws;

  // Byte count of a word size code
  function automatic logic [7:0] ws_bytes(input logic [2:0] code);
    ws_bytes = 8'h01 << code[1:0];
  endfunction

  // Step of a pointer by mode: 0 increment, 1 decrement, else fixed
  function automatic logic [31:0] stepped(input logic [31:0] p, input logic [1:0] m,
                                          input logic [7:0] b);
    stepped = (m == 2'h0) ? p + {24'h0, b} : (m == 2'h1) ? p - {24'h0, b} : p;
  endfunction

  assign len = channel_control_a[DLC_LEN_LSB +: DLC_LEN_W];
  assign sws = ws_bytes(channel_control_a[DLC_SWS_LSB +: 3]);
  assign dws = ws_bytes(channel_control_a[DLC_DWS_LSB +: 3]);
  assign src_sel = channel_config[DLC_SRC_HS_BIT];
  assign dst_sel = channel_config[DLC_DST_HS_BIT];
  assign len_zero = (len == 16'h0000);
  assign wr_done_cycle = WR && (ADDR == DLC_R_GLOBAL);

  // ************************************************************
  // Handshake
  // ************************************************************
  // Hardware handshake needs a request; software mode moves freely
  logic src_go, dst_go, running;
  assign running = (state_reg == DLC_RUN) && global_on_reg && !dis_req_reg;
  assign src_go = running && !sus_reg && (fifo_bytes_reg + sws <= DLC_FIFO_BYTES)
                  && !len_zero && (!src_sel || LINK.src_single || LINK.src_chunk);
  assign dst_go = running && (fifo_bytes_reg >= dws) && (!dst_sel || LINK.dst_single
                  || LINK.dst_chunk);
  // Acks withheld once disabling starts; peripherals tolerate that
  assign LINK.src_ack = src_go && src_sel;
  assign LINK.dst_ack = dst_go && dst_sel;

  // ************************************************************
  // Memory bus for list items and write-back
  // ************************************************************
  // Item base is taken from the pointer for the first word only, since the
  // fetch reloads that pointer halfway through the item
  logic [31:0] fetch_base;
  logic fetch_rd;
  assign fetch_base = (word_reg == 3'h0) ? descriptor_pointer : item_base_reg;
  // Five reads per item, none while the global bit is off
  assign fetch_rd = (state_reg == DLC_FETCH) && (word_reg < DLC_LI_WORDS)
                    && global_on_reg;
  assign LINK.mem_req = fetch_rd || (state_reg == DLC_WBACK);
  assign LINK.mem_we = (state_reg == DLC_WBACK);
  assign LINK.mem_addr = (state_reg == DLC_WBACK)
                         ? {item_base_reg[31:2], 2'h0} + DLC_LI_CTA
                         : {fetch_base[31:2], 2'h0} + {27'h0, word_reg, 2'h0};
  assign LINK.mem_layer = (state_reg == DLC_WBACK) ? item_base_reg[DLC_LAYER_LSB +: 2]
                          : fetch_base[DLC_LAYER_LSB +: 2];
  // Only length and finished bit differ from the fetched word
  assign LINK.mem_wdata = {1'b1, channel_control_a[30:0]};

  // Software writes config while idle only; global and last-buffer registers at any time
  always_ff @(posedge CLK) begin
    if (SRST) begin
      global_on_reg <= 1'b0;
      channel_config <= DLC_RST_CFG;
      last_a_reg <= DLC_RST_ZERO;
      last_b_reg <= DLC_RST_ZERO;
      last_d_reg <= DLC_RST_ZERO;
    end else if (WR) begin
      if (ADDR == DLC_R_GLOBAL) global_on_reg <= WDATA[0];
      if (ADDR == DLC_R_CFG && !en_reg) channel_config <= WDATA;
      if (ADDR == DLC_R_LAST_A) last_a_reg <= WDATA;
      if (ADDR == DLC_R_LAST_B) last_b_reg <= WDATA;
      if (ADDR == DLC_R_LAST_D) last_d_reg <= WDATA;
    end
  end

  // ************************************************************
  // Channel sequencer
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg <= DLC_IDLE;
      en_reg <= 1'b0;
      sus_reg <= 1'b0;
      dis_req_reg <= 1'b0;
      last_buf_reg <= 1'b0;
      word_reg <= 3'h0;
      item_base_reg <= DLC_RST_ZERO;
      fifo_bytes_reg <= 8'h00;
      channel_source_pointer <= DLC_RST_ZERO;
      channel_dest_pointer <= DLC_RST_ZERO;
      descriptor_pointer <= DLC_RST_ZERO;
      channel_control_a <= DLC_RST_ZERO;
      channel_control_b <= DLC_RST_ZERO;
    end else begin
      // Idle register writes
      if (WR && !en_reg) begin
        if (ADDR == DLC_R_SRC) channel_source_pointer <= WDATA;
        if (ADDR == DLC_R_DST) channel_dest_pointer <= WDATA;
        if (ADDR == DLC_R_DSC) descriptor_pointer <= WDATA;
        if (ADDR == DLC_R_CTA) channel_control_a <= WDATA;
        if (ADDR == DLC_R_CTB) channel_control_b <= WDATA;
      end
      // Suspend and resume on the enable command word
      if (WR && ADDR == DLC_R_ENCMD && WDATA[DLC_ST_SUS]) sus_reg <= 1'b1;
      if (WR && ADDR == DLC_R_ENCMD && WDATA[DLC_ST_SUS + 8]) sus_reg <= 1'b0;
      // Disable request from command or global clear
      if (en_reg && ((WR && ADDR == DLC_R_DISCMD && WDATA[0]) ||
                     (wr_done_cycle && !WDATA[0])))
        dis_req_reg <= 1'b1;
      case (state_reg)
        DLC_IDLE: begin
          if (WR && ADDR == DLC_R_ENCMD && WDATA[DLC_ST_EN]) begin
            en_reg <= 1'b1;
            dis_req_reg <= 1'b0;
            word_reg <= 3'h0;
            fifo_bytes_reg <= 8'h00;
            state_reg <= DLC_FETCH;
          end
        end
        DLC_FETCH: begin
          if (word_reg == 3'h0) item_base_reg <= descriptor_pointer;
          if (LINK.mem_rvalid) begin
            case ({word_reg - 3'h1, 2'h0})
              DLC_LI_SRC[4:0]: channel_source_pointer <= LINK.mem_rdata;
              DLC_LI_DST[4:0]: ; // Fetched but unused
              DLC_LI_DSC[4:0]: descriptor_pointer <= LINK.mem_rdata;
              DLC_LI_CTA[4:0]: channel_control_a <= LINK.mem_rdata;
              default: channel_control_b <= LINK.mem_rdata;
            endcase
          end
          // Fetch waits while the global bit is off; a disable then ends it
          if (word_reg < DLC_LI_WORDS) begin
            if (global_on_reg) word_reg <= word_reg + 3'h1;
            else if (dis_req_reg) state_reg <= DLC_DRAIN;
          end else if (!LINK.mem_rvalid) state_reg <= DLC_RUN;
        end
        DLC_RUN: begin
          if (src_go) begin
            channel_source_pointer <= stepped(channel_source_pointer,
              channel_control_b[DLC_SSTEP_LSB +: 2], sws);
            channel_control_a[DLC_LEN_LSB +: DLC_LEN_W] <= len - 16'h0001;
          end
          if (dst_go)
            channel_dest_pointer <= stepped(channel_dest_pointer,
              channel_control_b[DLC_DSTEP_LSB +: 2], dws);
          fifo_bytes_reg <= fifo_bytes_reg + (src_go ? sws : 8'h00) - (dst_go ? dws : 8'h00);
          if (dis_req_reg || !global_on_reg) state_reg <= DLC_DRAIN;
          else if (len_zero && channel_control_b[DLC_FLOW_LSB +: 2] == DLC_FLOW_DEV &&
                   fifo_bytes_reg < dws) begin
            // Sample end-of-buffer words against the final setting
            last_buf_reg <= (channel_control_a[30:0] == last_a_reg[30:0]) &&
                            (channel_control_b == last_b_reg) &&
                            (descriptor_pointer == last_d_reg);
            word_reg <= 3'h0;
            state_reg <= DLC_WBACK;
          end
        end
        DLC_WBACK: begin
          if (last_buf_reg || descriptor_pointer == DLC_RST_ZERO) begin
            en_reg <= 1'b0;
            state_reg <= DLC_IDLE;
          end else begin
            fifo_bytes_reg <= 8'h00;
            state_reg <= DLC_FETCH;
          end
        end
        DLC_DRAIN: begin
          // Disabled or global bit cleared: leftover bytes are dropped with the channel
          fifo_bytes_reg <= 8'h00;
          en_reg <= 1'b0;
          sus_reg <= 1'b0;
          dis_req_reg <= 1'b0;
          state_reg <= DLC_IDLE;
        end
        default: state_reg <= DLC_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Read port, data one cycle after the strobe
  // ************************************************************
  logic empty_flag;
  // Fewer bytes than one destination word is empty to software
  assign empty_flag = (fifo_bytes_reg < dws);
  always_ff @(posedge CLK) begin
    if (SRST) RDATA <= DLC_RST_ZERO;
    else if (RD) begin
      case (ADDR)
        DLC_R_GLOBAL: RDATA <= {31'h0, global_on_reg};
        DLC_R_STATE: RDATA <= {15'h0, empty_flag, 7'h0, sus_reg, 7'h0, en_reg};
        DLC_R_SRC: RDATA <= channel_source_pointer;
        DLC_R_DST: RDATA <= channel_dest_pointer;
        DLC_R_DSC: RDATA <= descriptor_pointer;
        DLC_R_CTA: RDATA <= channel_control_a;
        DLC_R_CTB: RDATA <= channel_control_b;
        DLC_R_CFG: RDATA <= channel_config;
        DLC_R_LAST_A: RDATA <= last_a_reg;
        DLC_R_LAST_B: RDATA <= last_b_reg;
        DLC_R_LAST_D: RDATA <= last_d_reg;
        default: RDATA <= DLC_RST_ZERO;
      endcase
    end else RDATA <= DLC_RST_ZERO;
  end
endmodule // dlc_channel

//--- dlc_link_if.sv
// Interface joining the channel controller to memory and the peripheral handshakes
`timescale 1ns/1ps
interface dlc_link_if;
  // Memory bus: one word per request, mem_rvalid one cycle later
  logic mem_req;
  logic mem_we;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [1:0] mem_layer;
  logic mem_rvalid;
  logic [31:0] mem_rdata;
  // Source and destination peripheral handshakes
  logic src_single;
  logic src_chunk;
  logic src_ack;
  logic dst_single;
  logic dst_chunk;
  logic dst_ack;
  modport ctrl (
    output mem_req, mem_we, mem_addr, mem_wdata, mem_layer,
    input mem_rvalid, mem_rdata,
    input src_single, src_chunk, dst_single, dst_chunk,
    output src_ack, dst_ack
  );
  modport periph (
    input mem_req, mem_we, mem_addr, mem_wdata, mem_layer,
    output mem_rvalid, mem_rdata,
    output src_single, src_chunk, dst_single, dst_chunk,
    input src_ack, dst_ack
  );
endinterface : dlc_link_if

//--- dlc_link_sva.sv
// Checker of the link between the channel controller and its far end
`timescale 1ns/1ps
module dlc_link_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Memory bus
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] mem_layer,
  input wire logic mem_rvalid,
  // Handshakes
  input wire logic src_single,
  input wire logic src_ack,
  input wire logic dst_single,
  input wire logic dst_ack
);
  // ********
  // Helper logic
  // ********
  logic [31:0] last_rd_reg;
  logic [1:0] last_lay_reg;
  logic rd_w;
  logic wr_w;
  assign rd_w = mem_req && !mem_we;
  assign wr_w = mem_req && mem_we;
  // Last fetched spot, since the write-back must land beside it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      last_rd_reg <= 32'h0;
      last_lay_reg <= 2'h0;
    end else if (rd_w) begin
      last_rd_reg <= mem_addr;
      last_lay_reg <= mem_layer;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // ********
  // Properties
  // ********
  property p_fetch_whole;
    $rose(rd_w) |-> rd_w [*5] ##1 !rd_w;
  endproperty
  a_fetch_whole: assert property (p_fetch_whole) else $error("item fetch not five words");
  property p_fetch_step;
    rd_w && $past(rd_w) |-> mem_addr == $past(mem_addr) + 32'h4;
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("item words not in order");
  property p_rvalid;
    mem_rvalid == $past(rd_w);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer not one cycle late");
  property p_wb_spot;
    wr_w |-> mem_addr == last_rd_reg - 32'h4 && mem_layer == last_lay_reg;
  endproperty
  a_wb_spot: assert property (p_wb_spot) else $error("write-back off its fetch spot");
  property p_wb_fields;
    wr_w |-> mem_wdata[31] && mem_wdata[15:0] == 16'h0;
  endproperty
  a_wb_fields: assert property (p_wb_fields) else $error("write-back fields wrong");
  property p_wb_single;
    wr_w |=> !wr_w;
  endproperty
  a_wb_single: assert property (p_wb_single) else $error("more than one word written");
  property p_ack_hw;
    src_ack |-> src_single;
  endproperty
  a_ack_hw: assert property (p_ack_hw) else $error("source ack without request");
  property p_src_drop;
    src_ack |=> !src_single;
  endproperty
  a_src_drop: assert property (p_src_drop) else $error("source request kept after ack");
  property p_dst_drop;
    dst_ack |=> !dst_single;
  endproperty
  a_dst_drop: assert property (p_dst_drop) else $error("sink request kept after ack");
  // Main scenarios reached
  c_fetch: cover property ($rose(rd_w));
  c_wb: cover property (wr_w);
  c_src: cover property (src_ack);
  c_dst: cover property (dst_ack);
endmodule // dlc_link_sva

//--- dlc_periph.sv
// Far end: list item memory and handshaking peripheral requests
`timescale 1ns/1ps
module dlc_periph
  import dlc_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Software loads of memory words
  input wire logic LOAD_WE,
  input wire logic [5:0] LOAD_ADDR,
  input wire logic [31:0] LOAD_DATA,
  // Request lines wanted by the user
  input wire logic SRC_WANT,
  input wire logic DST_WANT,
  // Link side
  dlc_link_if.periph LINK
);
  // ************************************************************
  // Memory of list items
  // ************************************************************
  logic [31:0] mem [DEPTH];
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic ssreq_reg, dsreq_reg;

  // Items linked and finished bits cleared by software loads
  always_ff @(posedge CLK) begin
    if (LOAD_WE) mem[LOAD_ADDR] <= LOAD_DATA;
    else if (LINK.mem_req && LINK.mem_we) mem[LINK.mem_addr[7:2]] <= LINK.mem_wdata;
  end

  // Read answer one cycle after request
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= DLC_RST_ZERO;
    end else begin
      rvalid_reg <= LINK.mem_req && !LINK.mem_we;
      rdata_reg <= mem[LINK.mem_addr[7:2]];
    end
  end
  assign LINK.mem_rvalid = rvalid_reg;
  assign LINK.mem_rdata = rdata_reg;

  // ************************************************************
  // Handshake requests
  // ************************************************************
  // Each ack drops its own line; channel enabled first by the user
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ssreq_reg <= 1'b0;
      dsreq_reg <= 1'b0;
    end else begin
      ssreq_reg <= SRC_WANT && !LINK.src_ack;
      dsreq_reg <= DST_WANT && !LINK.dst_ack;
    end
  end
  assign LINK.src_single = ssreq_reg;
  assign LINK.src_chunk = 1'b0;
  assign LINK.dst_single = dsreq_reg;
  assign LINK.dst_chunk = 1'b0;
endmodule // dlc_periph

//--- dlc_pkg.sv
// Package of constants and types shared by the channel list controller and its memory/peripheral end
package dlc_pkg;
  // ************************************************************
  // Widths and list item layout
  // ************************************************************
  localparam int DLC_AW = 32;
  localparam int DLC_DW = 32;
  localparam int DLC_NCH = 4;
  // Word offsets inside one list item
  localparam logic [31:0] DLC_LI_SRC = 32'h0000_0000;
  localparam logic [31:0] DLC_LI_DST = 32'h0000_0004;
  localparam logic [31:0] DLC_LI_DSC = 32'h0000_0008;
  localparam logic [31:0] DLC_LI_CTA = 32'h0000_000C;
  localparam logic [31:0] DLC_LI_CTB = 32'h0000_0010;
  localparam logic [2:0] DLC_LI_WORDS = 3'h5;
  // channel_control_a fields
  localparam int DLC_LEN_LSB = 0;
  localparam int DLC_LEN_W = 16;
  localparam int DLC_SWS_LSB = 24;
  localparam int DLC_DWS_LSB = 28;
  localparam int DLC_DONE_BIT = 31;
  // channel_control_b fields
  localparam int DLC_FLOW_LSB = 21;
  localparam int DLC_SSTEP_LSB = 24;
  localparam int DLC_DSTEP_LSB = 28;
  // channel_config fields
  localparam int DLC_SRC_HS_BIT = 9;
  localparam int DLC_DST_HS_BIT = 13;
  // descriptor_pointer layer bits
  localparam int DLC_LAYER_LSB = 0;
  // ************************************************************
  // Register port map of the controller
  // ************************************************************
  localparam logic [7:0] DLC_R_GLOBAL = 8'h04;
  localparam logic [7:0] DLC_R_ENCMD = 8'h28;
  localparam logic [7:0] DLC_R_DISCMD = 8'h2C;
  localparam logic [7:0] DLC_R_STATE = 8'h30;
  localparam logic [7:0] DLC_R_SRC = 8'h3C;
  localparam logic [7:0] DLC_R_DST = 8'h40;
  localparam logic [7:0] DLC_R_DSC = 8'h44;
  localparam logic [7:0] DLC_R_CTA = 8'h48;
  localparam logic [7:0] DLC_R_CTB = 8'h4C;
  localparam logic [7:0] DLC_R_CFG = 8'h50;
  localparam logic [7:0] DLC_R_LAST_A = 8'h54;
  localparam logic [7:0] DLC_R_LAST_B = 8'h58;
  localparam logic [7:0] DLC_R_LAST_D = 8'h5C;
  localparam logic [31:0] DLC_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] DLC_RST_CFG = 32'h0100_0000;
  // Channel state word layout: enable [0], suspend [8], empty [16]
  localparam int DLC_ST_EN = 0;
  localparam int DLC_ST_SUS = 8;
  localparam int DLC_ST_EMP = 16;
  localparam int DLC_FIFO_BYTES = 4;
  localparam logic [1:0] DLC_FLOW_DEV = 2'h0;
  // ************************************************************
  // Channel state machine
  // ************************************************************
  typedef enum logic [2:0] {
    DLC_IDLE, DLC_FETCH, DLC_RUN, DLC_WBACK, DLC_DRAIN
  } dlc_state_e;
endpackage : dlc_pkg

//--- dma_channel_list_control_test.sv
// Self-checking bench: channel controller facing list memory and peripherals
`timescale 1ns/1ps
module dma_channel_list_control_test;
  import dlc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic load_we = 1'b0;
  logic [5:0] load_addr = 6'h00;
  logic [31:0] load_data = 32'h0;
  logic src_want = 1'b0;
  logic dst_want = 1'b0;
  int num_errors = 0;
  int n_tests = 0;
  int acks = 0;
  int reads = 0;
  int a0, len0, len1, seed;
  logic [63:0] wbq[$];
  logic [31:0] d;
  dlc_link_if lk();
  dlc_channel dlc_channel_inst (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .LINK(lk.ctrl));
  dlc_periph dlc_periph_inst (.CLK(clk), .SRST(srst), .LOAD_WE(load_we),
    .LOAD_ADDR(load_addr), .LOAD_DATA(load_data), .SRC_WANT(src_want),
    .DST_WANT(dst_want), .LINK(lk.periph));
  dlc_link_sva dlc_link_sva_inst (.CLK(clk), .SRST(srst), .mem_req(lk.mem_req),
    .mem_we(lk.mem_we), .mem_addr(lk.mem_addr), .mem_wdata(lk.mem_wdata),
    .mem_layer(lk.mem_layer), .mem_rvalid(lk.mem_rvalid), .src_single(lk.src_single),
    .src_ack(lk.src_ack), .dst_single(lk.dst_single), .dst_ack(lk.dst_ack));
  // 25 ns clock
  always #12.5 clk = ~clk;
  // Monitor of write-backs, reads and source beats
  always @(posedge clk) begin
    if (lk.mem_req === 1'b1 && lk.mem_we === 1'b1) wbq.push_back({lk.mem_addr, lk.mem_wdata});
    if (lk.mem_req === 1'b1 && lk.mem_we === 1'b0) reads++;
    if (lk.src_ack === 1'b1) acks++;
  end
  // ********
  // Tasks
  // ********
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_wb(input logic [63:0] exp);
    logic [63:0] got;
    got = (wbq.size() > 0) ? wbq.pop_front() : 64'hX;
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic ld(input logic [5:0] w, input logic [31:0] v);
    @(posedge clk);
    load_addr <= w;
    load_data <= v;
    load_we <= 1'b1;
    @(posedge clk);
    load_we <= 1'b0;
  endtask
  // One list item; its destination word is junk that must stay unused
  task automatic item(input logic [5:0] w, input logic [31:0] dsc, input logic [31:0] cta);
    ld(w, 32'h0000_0080); // buffer start
    ld(w + 6'h1, 32'hDEAD_BEE0);
    ld(w + 6'h2, dsc); // next item or end
    ld(w + 6'h3, cta); // finished bit clear
    ld(w + 6'h4, 32'h0);
  endtask
  task automatic go(input logic [31:0] dsc, input logic [31:0] glb);
    wreg(DLC_R_DST, 32'h0000_0100);
    wreg(DLC_R_DSC, dsc);
    wreg(DLC_R_CFG, DLC_RST_CFG | (32'h1 << DLC_SRC_HS_BIT) | (32'h1 << DLC_DST_HS_BIT));
    wreg(DLC_R_GLOBAL, glb);
    wreg(DLC_R_ENCMD, 32'h1);
  endtask
  // Bounded poll of the enable status
  task automatic wait_idle();
    int i;
    for (i = 0; i < 300; i++) begin
      rreg(DLC_R_STATE, d);
      if (d[DLC_ST_EN] === 1'b0) break;
    end
    if (i == 300) begin
      num_errors++;
      $display("BAD t=%0t stuck state=%h exp=%h", $time, d, 32'h0);
      tally_and_finish();
    end
  endtask
  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    seed = $urandom(88);
    len0 = 1 + $urandom % 4;
    len1 = 1 + $urandom % 4;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rreg(DLC_R_CFG, d);
    cmp(d, DLC_RST_CFG);
    rreg(8'hFC, d);
    cmp(d, 32'h0);
    $display("test reset done");
    // Two chained items; destination continues across them
    item(6'h00, 32'h0000_0020, 32'(len0));
    // Second item links onward, so only the last-buffer match can stop it
    item(6'h08, 32'h0000_0040, 32'(len1));
    wreg(DLC_R_LAST_A, 32'h0); // length counted down at buffer end
    wreg(DLC_R_LAST_B, 32'h0);
    wreg(DLC_R_LAST_D, 32'h0000_0040);
    src_want <= 1'b1;
    dst_want <= 1'b1;
    wbq.delete();
    go(32'h0, 32'h1);
    rreg(DLC_R_STATE, d);
    cmp(d & 32'h1, 32'h1); // started
    wait_idle(); // cleared by hardware
    cmp_wb({32'h0000_000C, 32'h8000_0000}); // first write-back
    cmp_wb({32'h0000_002C, 32'h8000_0000}); // chained item
    cmp(32'(wbq.size()), 32'h0); // stops at last
    rreg(DLC_R_DST, d);
    cmp(d, 32'h100 + 32'(len0 + len1)); // contiguous sink
    rreg(DLC_R_SRC, d);
    cmp(d, 32'h80 + 32'(len1)); // source reloaded
    $display("test chain done");
    // Suspend, drain, resume
    item(6'h10, 32'h0, 32'h0000_0020);
    wbq.delete();
    go(32'h0000_0041, 32'h1); // item on layer 1
    repeat (12) @(posedge clk);
    wreg(DLC_R_ENCMD, 32'h0000_0100);
    repeat (20) @(posedge clk);
    a0 = acks;
    repeat (20) @(posedge clk);
    cmp(32'(acks - a0), 32'h0); // no source beats
    rreg(DLC_R_STATE, d);
    cmp(d & 32'h0001_0101, 32'h0001_0101); // suspended and empty
    wreg(DLC_R_ENCMD, 32'h0001_0000);
    wait_idle(); // completes
    cmp_wb({32'h0000_004C, 32'h8000_0000}); // normal end
    $display("test suspend done");
    // Abort by channel disable, then by global clear, with data held
    for (int m = 0; m < 2; m++) begin
      item(6'h18, 32'h0, 32'h0000_0030);
      dst_want <= 1'b0;
      wbq.delete();
      go(32'h0000_0060, 32'h1);
      repeat (30) @(posedge clk);
      wreg(m ? DLC_R_GLOBAL : DLC_R_DISCMD, m ? 32'h0 : 32'h1);
      wait_idle(); // abort lands
      cmp(32'(wbq.size()), 32'h0); // no write-back
      rreg(DLC_R_DST, d);
      cmp(d, 32'h100); // sink never asked
      rreg(DLC_R_STATE, d);
      cmp(d & 32'h0001_0000, 32'h0001_0000); // held data dropped
    end
    $display("test abort done");
    // Zero length item, held back while the global bit is off
    item(6'h20, 32'h0, 32'h0);
    dst_want <= 1'b1;
    a0 = reads;
    go(32'h0000_0080, 32'h0);
    repeat (10) @(posedge clk);
    cmp(32'(reads - a0), 32'h0); // no fetch while off
    wreg(DLC_R_GLOBAL, 32'h1);
    wait_idle(); // auto disable
    cmp(32'(reads - a0), 32'h5); // one item only
    $display("test zero length done");
    tally_and_finish();
  end
endmodule // dma_channel_list_control_test
